// ===== include/tacs_pkg.sv
// Package of constants for the touch converter serial command slave
`default_nettype none
package tacs_pkg;
  // ==========================================================
  // Address layout
  localparam logic [4:0] TACS_ADDR_PREFIX = 5'h0B; // Arbitrary type prefix
  localparam int TACS_DIR_BIT = 0;
  localparam int TACS_SEL_LO_BIT = 1;
  localparam int TACS_SEL_HI_BIT = 2;
  localparam int TACS_PREFIX_LSB = 3;
  // ==========================================================
  // Command byte fields
  localparam int TACS_CFG_MSB = 7;
  localparam int TACS_CFG_LSB = 4;
  localparam int TACS_PD_MSB = 3;
  localparam int TACS_PD_LSB = 2;
  localparam int TACS_RES_BIT = 1;
  localparam logic [7:0] TACS_CMD_RESET = 8'h00;
  // ==========================================================
  // Config codes
  localparam logic [3:0] TACS_CFG_TEMP_A = 4'h0;
  localparam logic [3:0] TACS_CFG_BAT_A = 4'h1;
  localparam logic [3:0] TACS_CFG_AUX_A = 4'h2;
  localparam logic [3:0] TACS_CFG_TEMP_B = 4'h4;
  localparam logic [3:0] TACS_CFG_BAT_B = 4'h5;
  localparam logic [3:0] TACS_CFG_AUX_B = 4'h6;
  localparam logic [3:0] TACS_CFG_DRV_XM = 4'h8;
  localparam logic [3:0] TACS_CFG_DRV_YM = 4'h9;
  localparam logic [3:0] TACS_CFG_DRV_YPXM = 4'hA;
  localparam logic [3:0] TACS_CFG_MEAS_X = 4'hC;
  localparam logic [3:0] TACS_CFG_MEAS_Y = 4'hD;
  localparam logic [3:0] TACS_CFG_MEAS_Z1 = 4'hE;
  localparam logic [3:0] TACS_CFG_MEAS_Z2 = 4'hF;
  // Multiplexer input encodings
  localparam logic [3:0] TACS_MUX_NONE = 4'h0;
  localparam logic [3:0] TACS_MUX_TEMP_A = 4'h1;
  localparam logic [3:0] TACS_MUX_TEMP_B = 4'h2;
  localparam logic [3:0] TACS_MUX_BAT_A = 4'h3;
  localparam logic [3:0] TACS_MUX_BAT_B = 4'h4;
  localparam logic [3:0] TACS_MUX_AUX_A = 4'h5;
  localparam logic [3:0] TACS_MUX_AUX_B = 4'h6;
  localparam logic [3:0] TACS_MUX_Y_PLUS = 4'h7;
  localparam logic [3:0] TACS_MUX_X_PLUS = 4'h8;
  localparam logic [3:0] TACS_MUX_Y_MINUS = 4'h9;
  // ==========================================================
  // Serial engine states
  typedef enum logic [5:0] {
    TACS_IDLE = 6'b00_0001,
    TACS_RX = 6'b00_0010,
    TACS_ACK = 6'b00_0100,
    TACS_TX = 6'b00_1000,
    TACS_MACK = 6'b01_0000,
    TACS_IGNORE = 6'b10_0000
  } tacs_state_e;
endpackage
`default_nettype wire

// ===== design/tacs_sync.sv
// Two-stage synchroniser with edge detection for the bus pins
`default_nettype none
module tacs_sync (
  input wire logic i_clk, // System clock
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_pin, // Asynchronous pin level
  output logic o_level, // Synchronised level
  output logic o_rise, // One-cycle rise pulse
  output logic o_fall // One-cycle fall pulse
);
  logic meta;
  logic sync;
  logic last;

  // Two flip-flops, then one for edges
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= i_pin;
      sync <= meta;
      last <= sync;
    end
  end

  // Edges seen by the second and third stage only
  assign o_level = sync;
  assign o_rise = sync & ~last;
  assign o_fall = ~sync & last;
endmodule
`default_nettype wire

// ===== design/tacs_cfg_decode.sv
// Decoder from config code to drivers, multiplexer and reference mode
`default_nettype none
module tacs_cfg_decode
  import tacs_pkg::*;
(
  input wire logic [3:0] i_cfg, // Config code
  output logic [3:0] o_mux, // Multiplexer input select
  output logic o_x_plus_drv, // X plus driver on
  output logic o_x_minus_drv, // X minus driver on
  output logic o_y_plus_drv, // Y plus driver on
  output logic o_y_minus_drv, // Y minus driver on
  output logic o_diff_ref, // Differential reference mode
  output logic o_convert, // Code asks for a conversion
  output logic o_temp, // Temperature channel
  output logic o_battery // Battery channel
);
  // Table lookup of the channel function
  always_comb begin
    o_mux = TACS_MUX_NONE;
    o_x_plus_drv = 1'b0;
    o_x_minus_drv = 1'b0;
    o_y_plus_drv = 1'b0;
    o_y_minus_drv = 1'b0;
    o_convert = 1'b1;
    o_temp = 1'b0;
    o_battery = 1'b0;
    o_diff_ref = i_cfg[3];
    case (i_cfg)
      TACS_CFG_TEMP_A: begin
        o_mux = TACS_MUX_TEMP_A;
        o_temp = 1'b1;
      end
      TACS_CFG_TEMP_B: begin
        o_mux = TACS_MUX_TEMP_B;
        o_temp = 1'b1;
      end
      TACS_CFG_BAT_A: begin
        o_mux = TACS_MUX_BAT_A;
        o_battery = 1'b1;
      end
      TACS_CFG_BAT_B: begin
        o_mux = TACS_MUX_BAT_B;
        o_battery = 1'b1;
      end
      TACS_CFG_AUX_A: o_mux = TACS_MUX_AUX_A;
      TACS_CFG_AUX_B: o_mux = TACS_MUX_AUX_B;
      TACS_CFG_DRV_XM: begin
        o_x_minus_drv = 1'b1;
        o_convert = 1'b0;
      end
      TACS_CFG_DRV_YM: begin
        o_y_minus_drv = 1'b1;
        o_convert = 1'b0;
      end
      TACS_CFG_DRV_YPXM: begin
        o_y_plus_drv = 1'b1;
        o_x_minus_drv = 1'b1;
        o_convert = 1'b0;
      end
      TACS_CFG_MEAS_X: begin
        o_mux = TACS_MUX_Y_PLUS;
        o_x_plus_drv = 1'b1;
        o_x_minus_drv = 1'b1;
      end
      TACS_CFG_MEAS_Y: begin
        o_mux = TACS_MUX_X_PLUS;
        o_y_plus_drv = 1'b1;
        o_y_minus_drv = 1'b1;
      end
      TACS_CFG_MEAS_Z1: begin
        o_mux = TACS_MUX_X_PLUS;
        o_x_minus_drv = 1'b1;
        o_y_plus_drv = 1'b1;
      end
      TACS_CFG_MEAS_Z2: begin
        o_mux = TACS_MUX_Y_MINUS;
        o_x_minus_drv = 1'b1;
        o_y_plus_drv = 1'b1;
      end
      default: o_convert = 1'b0; // Reserved codes drive nothing and start no conversion
    endcase
  end
endmodule
`default_nettype wire

// ===== design/tacs_i2c_slave.sv
// Serial bus command slave of the touch panel converter
// Functional notes
// - SDA falling while SCL high is a Start.
// - SDA rising while SCL high is a Stop, ending the transfer.
// - SDA steady while SCL high; changes then are conditions.
// - Bytes MSB first, one SCL pulse per bit, ninth bit acknowledge.
// - Same logic serves standard, fast and high-speed clock rates; here SCL low must outlast the three-clock SDA drive lag.
// - Acknowledger holds SDA low through the acknowledge SCL high.
// - No master acknowledge makes the device release SDA.
// - First byte is address: prefix, two select bits, direction.
// - Select bits come from the two address pins.
// - Address LSB one reads, zero writes.
// - Acknowledge only after prefix and select bits matched.
// - In receive mode acknowledge address and accepted bytes.
// - After a read address, shift data out on master SCL.
// - Repeated Start ends one transfer and begins the next.
// - Command byte sets channel, function and later power state.
// - Codes with MSB zero: single-ended, drivers off; all but 0011 and 0111 measure channels.
// - Codes 1000 to 1010 switch drivers only, differential.
// - Battery divider on only while sampling a battery channel.
// - Temperature bias on only while acquiring a temperature channel.
// - Power bits set reference, converter and pen interrupt enable.
// - Resolution bit zero is 12-bit, one is 8-bit.
// - Only first command byte of a write is acknowledged.
// - Read sends upper eight bits, then low four and zeros.
`default_nettype none
module tacs_i2c_slave
  import tacs_pkg::*;
(
  input wire logic i_clk, // System clock, 10 MHz
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_scl, // Bus clock pin
  input wire logic i_sda, // Bus data pin level
  output logic o_sda, // Bus data drive value, always low
  output logic o_sda_oe, // Bus data pull-down enable
  input wire logic i_addr_select_hi, // Board-tied select bit high
  input wire logic i_addr_select_lo, // Board-tied select bit low
  input wire logic [11:0] i_result, // Converter result
  input wire logic i_conv_done, // Converter finished, same clock
  output logic [3:0] o_mux_sel, // Multiplexer input select
  output logic o_x_plus_drv, // X plus driver
  output logic o_x_minus_drv, // X minus driver
  output logic o_y_plus_drv, // Y plus driver
  output logic o_y_minus_drv, // Y minus driver
  output logic o_diff_ref, // Differential reference mode
  output logic o_acquire, // Acquisition period active
  output logic o_convert_start, // One-cycle conversion start
  output logic o_battery_div_en, // Battery input divider enable
  output logic o_temp_bias_en, // Temperature diode bias enable
  output logic o_res_8bit, // Resolution: 1 for 8-bit
  output logic o_ref_on, // Internal reference on
  output logic o_adc_on, // Converter kept powered
  output logic o_pen_irq_en, // Pen touch interrupt enabled
  output logic [7:0] o_operation_command // Last accepted command
);
  // ==========================================================
  // Pin synchronisation
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;
  logic sda_drop;
  logic start_cond;
  logic stop_cond;

  tacs_sync u_scl_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_scl),
    .o_level(scl),
    .o_rise(scl_rise),
    .o_fall(scl_fall)
  );

  tacs_sync u_sda_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_sda),
    .o_level(sda),
    .o_rise(sda_rise),
    .o_fall(sda_fall)
  );

  // Pin straps caught by a two-flop chain
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end else begin
      sel_meta <= {i_addr_select_hi, i_addr_select_lo};
      sel_sync <= sel_meta;
    end
  end

  // Bus conditions: SDA edge while SCL high
  assign start_cond = sda_fall & scl;
  assign stop_cond = sda_rise & scl;
  // Edge-sampled design: SDA drive lags an SCL fall by three clocks, so SCL low must last longer
  assign sda_drop = 1'b0;

  // ==========================================================
  // Serial engine
  tacs_state_e state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic addr_phase;
  logic is_read;
  logic cmd_taken;
  logic ack_this;
  logic tx_low_half;
  logic [7:0] tx_byte;
  logic byte_done;
  logic [7:0] rx_byte;
  logic addr_match;
  logic cmd_strobe;
  logic tx_done;
  logic mack_seen;
  logic ack_slot;
  logic [7:0] tx_next;

  assign rx_byte = {shreg[6:0], sda};
  assign byte_done = scl_rise && (bit_cnt == 3'h7);
  assign addr_match =
    (rx_byte[7:TACS_PREFIX_LSB] == TACS_ADDR_PREFIX) &&
    (rx_byte[TACS_SEL_HI_BIT:TACS_SEL_LO_BIT] == sel_sync);
  assign cmd_strobe = (state == TACS_RX) && byte_done && !addr_phase &&
    !is_read && !cmd_taken;
  assign tx_byte = tx_low_half ? {i_result[3:0], 4'h0} :
    i_result[11:4];
  // Byte that follows a master acknowledge
  assign tx_next = tx_low_half ? i_result[11:4] :
    {i_result[3:0], 4'h0};

  // State transitions, sampled on SCL edges
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= TACS_IDLE;
    end else if (start_cond) begin
      state <= TACS_RX;
    end else if (stop_cond) begin
      state <= TACS_IDLE;
    end else begin
      case (state)
        TACS_IDLE: state <= TACS_IDLE;
        TACS_RX: begin
          if (byte_done) begin
            if (addr_phase && !addr_match) begin
              state <= TACS_IGNORE;
            end else begin
              state <= TACS_ACK;
            end
          end
        end
        TACS_ACK: begin
          if (scl_fall && ack_slot) begin
            state <= is_read ? TACS_TX : TACS_RX;
          end
        end
        TACS_TX: begin
          if (scl_fall && (bit_cnt == 3'h0) && tx_done) begin
            state <= TACS_MACK;
          end
        end
        TACS_MACK: begin
          if (scl_rise) begin
            state <= sda ? TACS_IGNORE : TACS_MACK;
          end else if (scl_fall && mack_seen) begin
            state <= TACS_TX;
          end
        end
        TACS_IGNORE: state <= TACS_IGNORE;
        default: state <= TACS_IDLE;
      endcase
    end
  end

  // Acknowledge slot opens on the fall after the eighth bit
  always_ff @(posedge i_clk) begin
    if (!i_resetn || start_cond) begin
      ack_slot <= 1'b0;
    end else if (state == TACS_ACK) begin
      if (scl_fall) begin
        ack_slot <= 1'b1;
      end
    end else begin
      ack_slot <= 1'b0;
    end
  end

  // Transmit completion and master acknowledge tracking
  always_ff @(posedge i_clk) begin
    if (!i_resetn || start_cond) begin
      tx_done <= 1'b0;
      mack_seen <= 1'b0;
    end else begin
      if (state == TACS_TX && scl_rise && bit_cnt == 3'h7) begin
        tx_done <= 1'b1;
      end else if (state != TACS_TX) begin
        tx_done <= 1'b0;
      end
      if (state == TACS_MACK && scl_rise) begin
        mack_seen <= ~sda;
      end else if (state != TACS_MACK) begin
        mack_seen <= 1'b0;
      end
    end
  end

  // Bit counter and receive shift register
  always_ff @(posedge i_clk) begin
    if (!i_resetn || start_cond) begin
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
    end else if ((state == TACS_RX || state == TACS_TX) && scl_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg <= rx_byte;
    end else if (state == TACS_ACK || state == TACS_MACK) begin
      bit_cnt <= 3'h0;
    end
  end

  // Transfer bookkeeping: address phase, direction, command taken
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      addr_phase <= 1'b1;
      is_read <= 1'b0;
      cmd_taken <= 1'b0;
      ack_this <= 1'b0;
    end else if (start_cond) begin
      addr_phase <= 1'b1;
      cmd_taken <= 1'b0;
      ack_this <= 1'b0;
    end else if (state == TACS_RX && byte_done) begin
      if (addr_phase) begin
        is_read <= rx_byte[TACS_DIR_BIT];
        ack_this <= addr_match;
        addr_phase <= 1'b0;
      end else begin
        ack_this <= !cmd_taken;
        cmd_taken <= 1'b1;
      end
    end
  end

  // Read half selector: upper then lower, repeating
  always_ff @(posedge i_clk) begin
    if (!i_resetn || start_cond) begin
      tx_low_half <= 1'b0;
    end else if (state == TACS_MACK && scl_fall && mack_seen) begin
      tx_low_half <= ~tx_low_half;
    end
  end

  // SDA pull-down, changed only after SCL falls
  always_ff @(posedge i_clk) begin
    if (!i_resetn || start_cond || stop_cond) begin
      o_sda_oe <= 1'b0;
    end else begin
      case (state)
        TACS_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= ack_slot ? (is_read & ~tx_byte[7]) :
              (ack_this | sda_drop);
          end
        end
        TACS_TX: begin
          if (scl_fall) begin
            o_sda_oe <= (bit_cnt == 3'h0 && tx_done) ? 1'b0 :
              ~tx_byte[3'h7 - bit_cnt];
          end
        end
        TACS_MACK: begin
          if (scl_fall) begin
            o_sda_oe <= mack_seen & ~tx_next[7];
          end
        end
        default: o_sda_oe <= 1'b0;
      endcase
    end
  end
  assign o_sda = 1'b0;

  // ==========================================================
  // Command register and acquisition
  logic [3:0] cfg;
  logic [3:0] dec_mux;
  logic dec_xp;
  logic dec_xm;
  logic dec_yp;
  logic dec_ym;
  logic dec_diff;
  logic dec_conv;
  logic dec_temp;
  logic dec_bat;
  logic [1:0] pd_bits;
  logic cmd_pending;
  logic conv_busy;

  assign cfg = o_operation_command[TACS_CFG_MSB:TACS_CFG_LSB];
  assign pd_bits = o_operation_command[TACS_PD_MSB:TACS_PD_LSB];

  tacs_cfg_decode u_cfg_decode (
    .i_cfg(cfg),
    .o_mux(dec_mux),
    .o_x_plus_drv(dec_xp),
    .o_x_minus_drv(dec_xm),
    .o_y_plus_drv(dec_yp),
    .o_y_minus_drv(dec_ym),
    .o_diff_ref(dec_diff),
    .o_convert(dec_conv),
    .o_temp(dec_temp),
    .o_battery(dec_bat)
  );

  // Command capture on the eighth bit of the first data byte
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_operation_command <= TACS_CMD_RESET;
      o_res_8bit <= 1'b0;
    end else if (cmd_strobe) begin
      o_operation_command <= rx_byte;
      o_res_8bit <= rx_byte[TACS_RES_BIT];
    end
  end

  // Acquisition from command end until Stop or repeated Start
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cmd_pending <= 1'b0;
      o_acquire <= 1'b0;
      o_convert_start <= 1'b0;
    end else begin
      o_convert_start <= 1'b0;
      if (cmd_strobe) begin
        cmd_pending <= 1'b1;
      end else if (cmd_pending && scl_fall) begin
        cmd_pending <= 1'b0;
        o_acquire <= 1'b1;
      end else if (o_acquire && (start_cond || stop_cond)) begin
        o_acquire <= 1'b0;
        o_convert_start <= dec_conv;
      end
    end
  end

  // Drivers, multiplexer and bias enables follow the command
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_mux_sel <= TACS_MUX_NONE;
      o_x_plus_drv <= 1'b0;
      o_x_minus_drv <= 1'b0;
      o_y_plus_drv <= 1'b0;
      o_y_minus_drv <= 1'b0;
      o_diff_ref <= 1'b0;
      o_battery_div_en <= 1'b0;
      o_temp_bias_en <= 1'b0;
    end else begin
      o_mux_sel <= o_acquire ? dec_mux : TACS_MUX_NONE;
      o_x_plus_drv <= dec_xp & (o_acquire | conv_busy | ~dec_conv);
      o_x_minus_drv <= dec_xm & (o_acquire | conv_busy | ~dec_conv);
      o_y_plus_drv <= dec_yp & (o_acquire | conv_busy | ~dec_conv);
      o_y_minus_drv <= dec_ym & (o_acquire | conv_busy | ~dec_conv);
      o_diff_ref <= dec_diff;
      o_battery_div_en <= dec_bat & o_acquire;
      o_temp_bias_en <= dec_temp & o_acquire;
    end
  end

  // Conversion busy, cleared by the converter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      conv_busy <= 1'b0;
    end else if (o_convert_start) begin
      conv_busy <= 1'b1;
    end else if (i_conv_done) begin
      conv_busy <= 1'b0;
    end
  end

  // Power state latched at end of command transfer
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ref_on <= 1'b0;
      o_adc_on <= 1'b0;
      o_pen_irq_en <= 1'b1;
    end else if (o_acquire && (start_cond || stop_cond)) begin
      o_ref_on <= pd_bits[1];
      o_adc_on <= pd_bits[0];
      o_pen_irq_en <= ~pd_bits[0];
    end
  end
endmodule
`default_nettype wire

// ===== bench/tacs_i2c_slave_sva.sv
// Assertion checker for the serial command slave ports
`default_nettype none
module tacs_i2c_slave_sva
  import tacs_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_scl, // Bus clock pin
  input wire logic i_sda, // Bus data pin
  input wire logic o_sda_oe, // Data pull enable
  input wire logic [3:0] o_mux_sel, // Mux select
  input wire logic o_x_plus_drv, // Driver
  input wire logic o_x_minus_drv, // Driver
  input wire logic o_y_plus_drv, // Driver
  input wire logic o_y_minus_drv, // Driver
  input wire logic o_diff_ref, // Reference mode
  input wire logic o_acquire, // Acquisition
  input wire logic o_convert_start, // Conversion pulse
  input wire logic o_battery_div_en, // Divider
  input wire logic o_temp_bias_en, // Bias
  input wire logic o_adc_on, // Converter power
  input wire logic o_pen_irq_en, // Pen interrupt enable
  input wire logic [7:0] o_operation_command // Command
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Command codes that ask for a conversion
  logic conv_code;
  assign conv_code = (o_operation_command[7:6] != 2'b10) &&
    !(!o_operation_command[7] && o_operation_command[5:4] == 2'b11);
  // ==========================================================
  // Bus events
  sequence s_stop_pin;
    i_scl && $rose(i_sda);
  endsequence
  sequence s_conv_pulse;
    o_convert_start ##1 !o_convert_start;
  endsequence
  // ==========================================================
  // Properties
  a_stop_conv: assert property (o_acquire && conv_code ##0 s_stop_pin |-> ##[1:6] o_convert_start)
    else $error("no conversion start after stop");
  a_conv_pulse: assert property (o_convert_start |-> $past(o_acquire) && !o_acquire ##0 s_conv_pulse)
    else $error("conversion pulse malformed");
  a_acq_ends: assert property ($fell(o_acquire) && conv_code |-> ##[0:1] o_convert_start)
    else $error("acquisition ended without conversion");
  a_oe_steady: assert property (i_scl && $past(i_scl, 2) |-> $stable(o_sda_oe))
    else $error("data drive changed while clock high");
  a_cmd_on_high: assert property ($changed(o_operation_command) |-> i_scl)
    else $error("command changed while clock low");
  a_bat_acq: assert property (o_battery_div_en |-> $past(o_acquire) && (o_mux_sel == TACS_MUX_BAT_A || o_mux_sel == TACS_MUX_BAT_B))
    else $error("divider on outside battery acquisition");
  a_temp_acq: assert property (o_temp_bias_en |-> $past(o_acquire) && (o_mux_sel == TACS_MUX_TEMP_A || o_mux_sel == TACS_MUX_TEMP_B))
    else $error("bias on outside temperature acquisition");
  a_pen_power: assert property (o_pen_irq_en != o_adc_on)
    else $error("pen enable disagrees with power mode");
  a_meas_x: assert property (o_acquire && o_mux_sel == TACS_MUX_Y_PLUS |-> {o_x_plus_drv, o_x_minus_drv, o_y_plus_drv, o_y_minus_drv} == 4'hC)
    else $error("x measurement drivers wrong");
  a_se_no_drv: assert property (o_acquire && !o_diff_ref |-> {o_x_plus_drv, o_x_minus_drv, o_y_plus_drv, o_y_minus_drv} == 4'h0)
    else $error("drivers on in single-ended mode");
endmodule
bind tacs_i2c_slave tacs_i2c_slave_sva u_sva (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe),
  .o_mux_sel(o_mux_sel), .o_x_plus_drv(o_x_plus_drv),
  .o_x_minus_drv(o_x_minus_drv), .o_y_plus_drv(o_y_plus_drv),
  .o_y_minus_drv(o_y_minus_drv), .o_diff_ref(o_diff_ref),
  .o_acquire(o_acquire), .o_convert_start(o_convert_start),
  .o_battery_div_en(o_battery_div_en), .o_temp_bias_en(o_temp_bias_en),
  .o_adc_on(o_adc_on), .o_pen_irq_en(o_pen_irq_en),
  .o_operation_command(o_operation_command));
`default_nettype wire

// ===== bench/tacs_master.sv
// Bus master model that clocks the serial link
`default_nettype none
module tacs_master (
  input wire logic i_clk, // Bench clock
  input wire logic i_sda, // Resolved data line
  output logic o_scl, // Bus clock drive
  output logic o_pull // High pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;
  int q = 2; // Clock cycles per quarter bit
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // Wait whole quarters, landing just after an edge
  task automatic wait_q(input int n);
    repeat (n * q) @(posedge i_clk);
    #1;
  endtask
  // Start from idle, or repeated start from clock low
  task automatic start();
    wait_q(1);
    o_pull = 1'b0;
    wait_q(1);
    o_scl = 1'b1;
    wait_q(1);
    o_pull = 1'b1;
    wait_q(1);
    o_scl = 1'b0;
  endtask
  // Stop, leaving the bus idle
  task automatic stop();
    wait_q(1);
    o_pull = 1'b1;
    wait_q(1);
    o_scl = 1'b1;
    wait_q(1);
    o_pull = 1'b0;
    wait_q(2);
  endtask
  // One bit: data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    wait_q(1);
    o_pull = !b;
    wait_q(1);
    o_scl = 1'b1;
    wait_q(1);
    r = i_sda;
    wait_q(1);
    o_scl = 1'b0;
  endtask
  // Byte, MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ma,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], rd[i]);
    bit_io(ma, ack);
  endtask
endmodule
`default_nettype wire

// ===== bench/test_tacs_i2c_slave.sv
// Self-checking bench of the serial command slave
`default_nettype none
module test_tacs_i2c_slave;
  import tacs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
  logic clk, resetn, scl, pull, sda, sda_out, sda_oe, hi, lo, conv_done;
  logic xp, xm, yp, ym, diff, acq, cst, bat, temp, res8, ref_on, adc_on, pen;
  logic [11:0] result, e, obs;
  logic [3:0] mux;
  logic [7:0] cmd_reg, rnd, cmd, addr, rd;
  logic [7:0] bad [3] = '{8'h80, 8'h04, 8'h02};
  logic ack;
  int err_count = 0, compares = 0, conv_cnt = 0, c0, n;
  // Open-drain data line with pull-up
  assign sda = !(pull || (sda_oe && !sda_out));
  assign obs = {mux, xp, xm, yp, ym, diff, temp, bat, acq};
  tacs_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
  tacs_i2c_slave dut (.i_clk(clk), .i_resetn(resetn), .i_scl(scl),
    .i_sda(sda), .o_sda(sda_out), .o_sda_oe(sda_oe),
    .i_addr_select_hi(hi), .i_addr_select_lo(lo), .i_result(result),
    .i_conv_done(conv_done), .o_mux_sel(mux), .o_x_plus_drv(xp),
    .o_x_minus_drv(xm), .o_y_plus_drv(yp), .o_y_minus_drv(ym),
    .o_diff_ref(diff), .o_acquire(acq), .o_convert_start(cst),
    .o_battery_div_en(bat), .o_temp_bias_en(temp), .o_res_8bit(res8),
    .o_ref_on(ref_on), .o_adc_on(adc_on), .o_pen_irq_en(pen),
    .o_operation_command(cmd_reg));
  // Expected {mux, xp, xm, yp, ym, diff, temp, bat, conv} per code
  function automatic logic [11:0] exp_of(input logic [3:0] c);
    case (c)
      4'h0: return {TACS_MUX_TEMP_A, 8'h05};
      4'h1: return {TACS_MUX_BAT_A, 8'h03};
      4'h2: return {TACS_MUX_AUX_A, 8'h01};
      4'h4: return {TACS_MUX_TEMP_B, 8'h05};
      4'h5: return {TACS_MUX_BAT_B, 8'h03};
      4'h6: return {TACS_MUX_AUX_B, 8'h01};
      4'h8: return {TACS_MUX_NONE, 8'h48};
      4'h9: return {TACS_MUX_NONE, 8'h18};
      4'hA: return {TACS_MUX_NONE, 8'h68};
      4'hB: return {TACS_MUX_NONE, 8'h08};
      4'hC: return {TACS_MUX_Y_PLUS, 8'hC9};
      4'hD: return {TACS_MUX_X_PLUS, 8'h39};
      4'hE: return {TACS_MUX_X_PLUS, 8'h69};
      4'hF: return {TACS_MUX_Y_MINUS, 8'h69};
      default: return {TACS_MUX_NONE, 8'h00};
    endcase
  endfunction
  // Pseudo-random source
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Count conversion pulses
  always @(posedge clk) if (cst === 1'b1) conv_cnt++;
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    {resetn, hi, lo, conv_done, result, rnd} = {4'h0, 12'h000, 8'h42};
    tick(8);
    resetn = 1'b1;
    tick(3);
    `CHK({sda_oe, pen, cmd_reg, acq}, {2'b01, TACS_CMD_RESET, 1'b0})
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      {hi, lo} = rnd[1:0];
      result = {rnd, rnd[7:4]} ^ 12'h5A3;
      m.q = (i >= 14) ? 4 : 2;
      cmd = {i[3:0], rnd[5:4], rnd[6], 1'b0};
      e = exp_of(cmd[7:4]);
      c0 = conv_cnt;
      addr = {TACS_ADDR_PREFIX, hi, lo, 1'b0};
      tick(4);
      m.start();
      m.xfer(addr, 1'b1, rd, ack);
      `CHK(ack, 1'b0)
      m.xfer(cmd, 1'b1, rd, ack);
      `CHK(ack, 1'b0)
      `CHK(cmd_reg, cmd)
      if (e[0]) `CHK(obs, e)
      else `CHK(obs[7:1], e[7:1])
      if (i[2]) begin
        m.xfer(~cmd, 1'b1, rd, ack);
        `CHK(ack, 1'b1)
        `CHK(cmd_reg, cmd)
      end
      if (i[0]) begin
        m.start();
        m.xfer(addr | 8'h01, 1'b1, rd, ack);
        `CHK(ack, 1'b0)
        n = i[1] ? 3 : 1;
        for (int k = 0; k <= n; k++) begin
          m.xfer(8'hFF, k == n, rd, ack);
          `CHK(rd, k[0] ? {result[3:0], 4'h0} : result[11:4])
        end
        tick(6);
        `CHK(sda_oe, 1'b0)
      end
      m.stop();
      tick(2);
      `CHK(conv_cnt - c0, int'(e[0]))
      `CHK({ref_on, adc_on, pen, res8, temp, bat},
           {cmd[3:2], !cmd[2], cmd[1], 2'b00})
      conv_done = 1'b1;
      tick(1);
      conv_done = 1'b0;
      $display("Write of code %0h done", i);
    end
    for (int j = 0; j < 3; j++) begin
      tick(4);
      m.start();
      m.xfer({TACS_ADDR_PREFIX, hi, lo, 1'b0} ^ bad[j], 1'b1, rd, ack);
      `CHK(ack, 1'b1)
      m.xfer(8'hC0, 1'b1, rd, ack);
      `CHK(ack, 1'b1)
      m.stop();
      `CHK(cmd_reg, cmd)
      $display("Foreign address %0d done", j);
    end
    test_done();
  end
endmodule
`default_nettype wire
